// file: src/sitd_pkg.sv
// Package for the I2C timing and data-path register slice.
// Assumes a 250 MHz core clock and an oscillator period of 40 ns.
package sitd_pkg;
  // Register offsets
  localparam logic [7:0] OFS_CLK_HIGH = 8'h18;
  localparam logic [7:0] OFS_CLK_LOW = 8'h19;
  localparam logic [7:0] OFS_DP_OPT2 = 8'h1a;
  localparam logic [7:0] OFS_BIST_ERR = 8'h1b;
  // Reset values
  localparam logic [7:0] RST_CLK_HIGH = 8'h7f;
  localparam logic [7:0] RST_CLK_LOW = 8'h7f;
  localparam logic [7:0] RST_BIST_ERR = 8'h00;
  localparam logic RST_WIDE_MODE = 1'b0;
  localparam logic RST_SURROUND = 1'b0;
  // Field positions in the data-path options register
  localparam int BIT_SECOND_AUDIO = 3;
  localparam int BIT_WIDE_MODE = 1;
  localparam int BIT_SURROUND = 0;
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int OSC_PERIOD_PS = 40000;
  localparam int OSC_CYCLES = (OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [11:0] OSC_CYC = 12'(OSC_CYCLES);
  localparam logic [11:0] EXTRA_PERIODS = 12'h005;
  localparam logic [7:0] ERR_MAX = 8'hff;
  localparam int PHASE_W = 12;
  // Master clock phases, Gray coded
  typedef enum logic [1:0] {
    SITD_IDLE = 2'b00,
    SITD_LOW = 2'b01,
    SITD_HIGH = 2'b11
  } sitd_state_t;
endpackage : sitd_pkg

// file: src/sitd_regs.sv
// Register slice 0x18..0x1b: I2C master clock timing, data-path options,
// back-channel self-test error counter.
// Assumes the I2C slave decoder supplies single-cycle register strobes on mclk.
`timescale 1ns/10ps
`default_nettype none

module sitd_regs #(
  parameter int DATA_W = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  // Register access from the I2C slave
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [DATA_W-1:0] regWrData,
  output logic [DATA_W-1:0] regRdData,
  // Local I2C master clock pin (open drain)
  input wire logic masterRun,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  output logic sclHighPhase,
  // Back-channel slave clock stretching
  input wire logic slaveStretchReq,
  input wire logic slaveDataReady,
  output logic slaveSclHold,
  // Auxiliary audio control from the bridge configuration register
  input wire logic strap_pin_zero,
  input wire logic auxAudioWrEn,
  input wire logic auxAudioWrData,
  output logic auxAudioEn,
  // Data path options
  input wire logic [1:0] i2sChanSel,
  input wire logic repeaterMode,
  input wire logic inbandModeValid,
  input wire logic inbandSurround,
  output logic wide_serial_mode,
  output logic surroundEn,
  output logic dataIslandOnly,
  output logic [1:0] audioChanSel,
  // Self-test error counting
  input wire logic bistActive,
  input wire logic bistStart,
  input wire logic errCountClear,
  input wire logic bcCrcError
);

  // Phase length in core cycles: (field + 5) oscillator periods
  function automatic logic [sitd_pkg::PHASE_W-1:0] phase_cycles(input logic [7:0] field);
    phase_cycles = 12'(({4'h0, field} + sitd_pkg::EXTRA_PERIODS) * sitd_pkg::OSC_CYC);
  endfunction : phase_cycles

  logic [7:0] highCount_reg, highCount_next;
  logic [7:0] lowCount_reg, lowCount_next;
  logic wideMode_reg, wideMode_next;
  logic surround_reg, surround_next;
  logic [7:0] errCount_reg, errCount_next;
  logic auxAudio_reg, auxAudio_next;
  logic strapPending_reg, strapPending_next;
  logic [1:0] sclSync_reg, sclSync_next;
  logic [1:0] strapSync_reg, strapSync_next;
  sitd_pkg::sitd_state_t state_reg, state_next;
  logic [sitd_pkg::PHASE_W-1:0] phaseCnt_reg, phaseCnt_next;
  logic [sitd_pkg::PHASE_W-1:0] setupCnt_reg, setupCnt_next;
  logic setupRun_reg, setupRun_next;
  logic hold_reg, hold_next;
  logic sclOe_reg, sclOe_next;
  logic highPhase_reg, highPhase_next;
  logic [DATA_W-1:0] rdData_reg, rdData_next;
  logic surroundEff_reg, surroundEff_next;
  logic dataIsland_reg, dataIsland_next;
  logic [1:0] chanSel_reg, chanSel_next;

  // Next-state logic for all register groups
  always_comb begin
    highCount_next = highCount_reg;
    lowCount_next = lowCount_reg;
    wideMode_next = wideMode_reg;
    surround_next = surround_reg;
    errCount_next = errCount_reg;
    auxAudio_next = auxAudio_reg;
    strapPending_next = 1'b0;
    state_next = state_reg;
    phaseCnt_next = phaseCnt_reg;
    setupCnt_next = setupCnt_reg;
    setupRun_next = setupRun_reg;
    hold_next = hold_reg;
    sclOe_next = sclOe_reg;
    highPhase_next = 1'b0;
    // Strap and pin inputs are asynchronous, so two stages before use
    sclSync_next = {sclSync_reg[0], sclIn};
    strapSync_next = {strapSync_reg[0], strap_pin_zero};

    // Register writes; reserved bits of 0x1a are simply not stored
    if (regWrEn) begin
      case (regAddr)
        sitd_pkg::OFS_CLK_HIGH: highCount_next = regWrData[7:0];
        sitd_pkg::OFS_CLK_LOW: lowCount_next = regWrData[7:0];
        sitd_pkg::OFS_DP_OPT2: begin
          wideMode_next = regWrData[sitd_pkg::BIT_WIDE_MODE];
          surround_next = regWrData[sitd_pkg::BIT_SURROUND];
        end
        default: ;
      endcase
    end

    // Strap is caught once, right after reset release
    if (strapPending_reg) begin
      auxAudio_next = strapSync_reg[1];
    end else if (auxAudioWrEn) begin
      auxAudio_next = auxAudioWrData;
    end

    // Error counter: an error in the clearing cycle still counts as one
    if (bistStart || errCountClear) begin
      errCount_next = (bistActive && bcCrcError) ? 8'h01 : 8'h00;
    end else if (bistActive && bcCrcError && errCount_reg != sitd_pkg::ERR_MAX) begin
      errCount_next = errCount_reg + 8'h01;
    end

    // Master clock generator; high time counts only once the pin is seen high
    case (state_reg)
      sitd_pkg::SITD_IDLE: begin
        sclOe_next = 1'b0;
        if (masterRun) begin
          state_next = sitd_pkg::SITD_LOW;
          sclOe_next = 1'b1;
          phaseCnt_next = phase_cycles(lowCount_reg);
        end
      end
      sitd_pkg::SITD_LOW: begin
        if (phaseCnt_reg > 12'h001) begin
          phaseCnt_next = phaseCnt_reg - 12'h001;
        end else begin
          state_next = sitd_pkg::SITD_HIGH;
          sclOe_next = 1'b0;
          phaseCnt_next = phase_cycles(highCount_reg);
        end
      end
      sitd_pkg::SITD_HIGH: begin
        highPhase_next = 1'b1;
        // A slave stretching the clock holds the count
        if (sclSync_reg[1]) begin
          if (phaseCnt_reg > 12'h001) begin
            phaseCnt_next = phaseCnt_reg - 12'h001;
          end else if (masterRun) begin
            state_next = sitd_pkg::SITD_LOW;
            sclOe_next = 1'b1;
            phaseCnt_next = phase_cycles(lowCount_reg);
          end else begin
            state_next = sitd_pkg::SITD_IDLE;
          end
        end
      end
      default: begin
        state_next = sitd_pkg::SITD_IDLE;
        sclOe_next = 1'b0;
      end
    endcase

    // Slave stretch: hold SCL, then give SDA the low-time setup before release
    if (slaveStretchReq) begin
      hold_next = 1'b1;
    end
    if (hold_reg && slaveDataReady && !setupRun_reg) begin
      setupRun_next = 1'b1;
      setupCnt_next = phase_cycles(lowCount_reg);
    end else if (setupRun_reg) begin
      if (setupCnt_reg > 12'h001) begin
        setupCnt_next = setupCnt_reg - 12'h001;
      end else begin
        setupRun_next = 1'b0;
        hold_next = slaveStretchReq;
      end
    end

    // In-band detection in a repeater wins over the register bit
    surroundEff_next = (repeaterMode && inbandModeValid) ? inbandSurround : surround_reg;
    dataIsland_next = surroundEff_next;
    chanSel_next = i2sChanSel;

    // Read data registered one cycle behind the address
    rdData_next = '0;
    case (regAddr)
      sitd_pkg::OFS_CLK_HIGH: rdData_next[7:0] = highCount_reg;
      sitd_pkg::OFS_CLK_LOW: rdData_next[7:0] = lowCount_reg;
      sitd_pkg::OFS_DP_OPT2: begin
        rdData_next[sitd_pkg::BIT_SECOND_AUDIO] = auxAudio_reg;
        rdData_next[sitd_pkg::BIT_WIDE_MODE] = wideMode_reg;
        rdData_next[sitd_pkg::BIT_SURROUND] = surround_reg;
      end
      sitd_pkg::OFS_BIST_ERR: rdData_next[7:0] = errCount_reg;
      default: rdData_next = '0;
    endcase
  end

  // Strap synchroniser stays out of reset, so it already holds the pin level at release
  always_ff @(posedge mclk) begin
    strapSync_reg <= strapSync_next;
  end

  // Register fields, strap capture and read data
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      highCount_reg <= sitd_pkg::RST_CLK_HIGH;
      lowCount_reg <= sitd_pkg::RST_CLK_LOW;
      wideMode_reg <= sitd_pkg::RST_WIDE_MODE;
      surround_reg <= sitd_pkg::RST_SURROUND;
      errCount_reg <= sitd_pkg::RST_BIST_ERR;
      // Cleared here, then loaded from the strap at the first edge after release
      auxAudio_reg <= 1'b0;
      strapPending_reg <= 1'b1;
      // Read data starts at zero so the first read after reset is clean
      rdData_reg <= '0;
    end else begin
      highCount_reg <= highCount_next;
      lowCount_reg <= lowCount_next;
      wideMode_reg <= wideMode_next;
      surround_reg <= surround_next;
      errCount_reg <= errCount_next;
      auxAudio_reg <= auxAudio_next;
      strapPending_reg <= strapPending_next;
      rdData_reg <= rdData_next;
    end
  end

  // Master clock generator state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // Synchroniser idles high, like the pulled-up pin, so no false fall after reset
      sclSync_reg <= 2'b11;
      state_reg <= sitd_pkg::SITD_IDLE;
      phaseCnt_reg <= '0;
      sclOe_reg <= 1'b0;
      highPhase_reg <= 1'b0;
    end else begin
      sclSync_reg <= sclSync_next;
      state_reg <= state_next;
      phaseCnt_reg <= phaseCnt_next;
      sclOe_reg <= sclOe_next;
      highPhase_reg <= highPhase_next;
    end
  end

  // Back-channel clock stretch state
  always_ff @(posedge mclk) begin
    // A reset drops the hold; a slave in mid-access has to start over
    if (sys_rst) begin
      setupCnt_reg <= '0;
      setupRun_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      setupCnt_reg <= setupCnt_next;
      setupRun_reg <= setupRun_next;
      hold_reg <= hold_next;
    end
  end

  // Data path options, one cycle behind their sources
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      surroundEff_reg <= 1'b0;
      dataIsland_reg <= 1'b0;
      chanSel_reg <= 2'b00;
    end else begin
      surroundEff_reg <= surroundEff_next;
      dataIsland_reg <= dataIsland_next;
      chanSel_reg <= chanSel_next;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sclOut = 1'b0;
  assign sclOe = sclOe_reg;
  assign sclHighPhase = highPhase_reg;
  assign slaveSclHold = hold_reg;
  assign auxAudioEn = auxAudio_reg;
  assign wide_serial_mode = wideMode_reg;
  assign surroundEn = surroundEff_reg;
  assign dataIslandOnly = dataIsland_reg;
  assign audioChanSel = chanSel_reg;
  assign regRdData = rdData_reg;

endmodule : sitd_regs

`default_nettype wire

// file: tb/sitd_chk.sv
// Checker for the I2C timing and data-path register slice.
// Bound to sitd_regs; fields are not rewritten while SCL runs.
`timescale 1ns/10ps
`default_nettype none
module sitd_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic sclOe,
  input wire logic sclHighPhase,
  input wire logic slaveStretchReq,
  input wire logic slaveDataReady,
  input wire logic slaveSclHold,
  input wire logic repeaterMode,
  input wire logic inbandModeValid,
  input wire logic inbandSurround,
  input wire logic surroundEn,
  input wire logic dataIslandOnly
);
  logic [7:0] hi_reg, hi_next, lo_reg, lo_next;
  logic sur_reg, sur_next;
  logic [15:0] lowRun_reg, lowRun_next, highRun_reg, highRun_next, holdRun_reg, holdRun_next;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Shadow fields and phase run lengths; reset folded in here
  always_comb begin
    hi_next = sys_rst ? 8'h7f : (regWrEn && regAddr == 8'h18) ? regWrData : hi_reg;
    lo_next = sys_rst ? 8'h7f : (regWrEn && regAddr == 8'h19) ? regWrData : lo_reg;
    sur_next = sys_rst ? 1'b0 : (regWrEn && regAddr == 8'h1a) ? regWrData[0] : sur_reg;
    lowRun_next = sclOe ? lowRun_reg + 16'h0001 : 16'h0000;
    highRun_next = sclHighPhase ? highRun_reg + 16'h0001 : 16'h0000;
    holdRun_next = slaveDataReady ? 16'h0001 : holdRun_reg + 16'h0001;
  end
  // Plain registers only
  always_ff @(posedge mclk) begin
    {hi_reg, lo_reg} <= {hi_next, lo_next};
    sur_reg <= sur_next;
    {lowRun_reg, highRun_reg, holdRun_reg} <= {lowRun_next, highRun_next, holdRun_next};
  end
  a_field_read: assert property (!$past(sys_rst) && $past(regAddr[7:1]) == 7'h0c
    |-> regRdData == ($past(regAddr[0]) ? $past(lo_reg) : $past(hi_reg))) else $error("timing field read wrong");
  a_resv_zero: assert property (!$past(sys_rst) && $past(regAddr) == 8'h1a
    |-> regRdData[7:4] == 4'h0 && regRdData[2] == 1'b0) else $error("reserved bits not zero");
  a_low_exact: assert property ($fell(sclOe) |-> lowRun_reg == (lo_reg + 5) * 10)
    else $error("low phase length wrong");
  a_high_min: assert property ($fell(sclHighPhase) |-> highRun_reg >= (hi_reg + 5) * 10)
    else $error("high phase too short");
  a_hold_setup: assert property ($fell(slaveSclHold) |-> holdRun_reg >= (lo_reg + 5) * 10)
    else $error("slave hold released early");
  a_hold_take: assert property (slaveStretchReq |=> slaveSclHold) else $error("stretch not taken");
  a_surr_over: assert property (repeaterMode && inbandModeValid |=> surroundEn == $past(inbandSurround))
    else $error("surround override wrong");
  a_island_only: assert property (!$past(sys_rst) |-> dataIslandOnly ==
    ($past(repeaterMode) && $past(inbandModeValid) ? $past(inbandSurround) : $past(sur_reg)))
    else $error("transport not island");
endmodule : sitd_chk
bind sitd_regs sitd_chk chk_u (.*);
`default_nettype wire

// file: tb/sitd_i2c_peer.sv
// Slow I2C device on the local bus: stretches SCL after each fall seen while idle, if stretchCyc is non-zero.
// Assumes the bench resolves the open-drain SCL wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module sitd_i2c_peer (
  input wire logic clk,
  input wire logic scl,
  input wire logic [11:0] stretchCyc,
  output logic pullLow
);
  // Zero length means a prompt peer; busy peers miss further falls
  initial pullLow = 1'b0;
  always @(negedge scl) begin
    if (stretchCyc != 12'h000) begin
      pullLow <= 1'b1;
      repeat (stretchCyc) @(posedge clk);
      pullLow <= 1'b0;
    end
  end
endmodule : sitd_i2c_peer
`default_nettype wire

// file: tb/testbench.sv
// Bench for the I2C timing and data-path register slice.
// Drives the register strobe port and levels; a peer stretches SCL.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk, sys_rst, regWrEn, masterRun, slaveStretchReq, slaveDataReady, strap_pin_zero, auxAudioWrEn;
  logic auxAudioWrData, repeaterMode, inbandModeValid, inbandSurround, bistActive, bistStart, errCountClear;
  logic bcCrcError, pullLow, sclOut, sclOe, sclHighPhase, slaveSclHold, auxAudioEn, wide_serial_mode;
  logic surroundEn, dataIslandOnly;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [1:0] i2sChanSel, audioChanSel;
  logic [11:0] stretchCyc;
  logic [31:0] seed;
  wire sclIn;
  int failures, compares, hiM, loM, dpM, auxM, errM, n, k;
  // Open-drain SCL with pull-up
  assign sclIn = !(sclOe || pullLow);
  sitd_regs dut_u (.*);
  sitd_i2c_peer peer_u (.clk(mclk), .scl(sclIn), .stretchCyc(stretchCyc), .pullLow(pullLow));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = !mclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Expected read value of each byte address
  function automatic logic [7:0] mdl(input logic [7:0] a);
    case (a)
      8'h18: return 8'(hiM);
      8'h19: return 8'(loM);
      8'h1a: return {4'h0, 1'(auxM), 1'b0, 2'(dpM)};
      8'h1b: return 8'(errM);
      default: return 8'h00;
    endcase
  endfunction : mdl
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task automatic tmo();
    if (n >= 3000) begin
      failures++;
      test_done();
    end
  endtask : tmo
  // Inputs always move 1 ns after the edge
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    tick(1);
    regWrEn = 1'b0;
    if (a == 8'h18) hiM = d;
    if (a == 8'h19) loM = d;
    if (a == 8'h1a) dpM = d[1:0];
  endtask : wr
  task automatic rd(input logic [7:0] a);
    regAddr = a;
    tick(1);
    chk(regRdData, mdl(a));
  endtask : rd
  initial begin
    {regWrEn, masterRun, slaveStretchReq, slaveDataReady, auxAudioWrEn, auxAudioWrData, repeaterMode} = '0;
    {inbandModeValid, inbandSurround, bistActive, bistStart, errCountClear, bcCrcError} = '0;
    {regAddr, regWrData, i2sChanSel, stretchCyc, strap_pin_zero} = {30'h0, 1'b1};
    {seed, failures, compares, hiM, loM, dpM, auxM, errM} = {32'd12275, 32'd0, 32'd0, 32'd127, 32'd127, 96'd0};
    auxM = 1;
    sys_rst = 1'b1;
    tick(6);
    sys_rst = 1'b0;
    tick(2);
    // Defaults, strap capture and an unmapped place
    for (k = 0; k < 5; k++) rd(8'h18 + 8'(k));
    for (k = 0; k < 24; k++) begin
      n = int'(rnd() % 5);
      wr(8'h18 + 8'(n), 8'(rnd()));
      rd(8'h18 + 8'(n));
      chk(16'(wide_serial_mode), 16'(dpM / 2));
    end
    // Surround select against in-band override
    for (k = 0; k < 32; k++) begin
      {repeaterMode, inbandModeValid, inbandSurround, i2sChanSel} = 5'(rnd());
      if (k % 8 == 0) wr(8'h1a, 8'(rnd()));
      tick(1);
      chk(16'(surroundEn), 16'(repeaterMode && inbandModeValid ? int'(inbandSurround) : dpM % 2));
      chk(16'(audioChanSel), 16'(i2sChanSel));
      chk(16'(dataIslandOnly), 16'(repeaterMode && inbandModeValid ? int'(inbandSurround) : dpM % 2));
    end
    for (k = 0; k < 2; k++) begin
      {auxAudioWrData, auxM} = {k[0], k};
      pulse(auxAudioWrEn);
      rd(8'h1a);
      chk(16'(auxAudioEn), 16'(auxM));
    end
    // Error counter: saturate, clear both ways, idle outside self test
    // Error line held up between counts, dropped only around a read
    bistActive = 1'b1;
    for (k = 0; k < 263; k++) begin
      bcCrcError = 1'b1;
      tick(1);
      if (errM < 255) errM++;
      if (k == 259) {errM, errCountClear} = {32'd0, 1'b1};
      if (k == 260) {errM, bistStart, errCountClear} = {32'd0, 1'b1, 1'b0};
      if (k == 261) bistStart = 1'b0;
      if (k == 100 || k == 258 || k == 262) begin
        bcCrcError = 1'b0;
        rd(8'h1b);
      end
    end
    bistActive = 1'b0;
    pulse(bcCrcError);
    rd(8'h1b);
    // Master SCL phases, prompt and stretched peer
    wr(8'h18, 8'h03);
    tick(1);
    wr(8'h19, 8'h02);
    for (k = 0; k < 2; k++) begin
      {stretchCyc, masterRun} = {12'(k * 90), 1'b1};
      for (n = 0; n < 3000 && !sclOe; n++) tick(1);
      tmo();
      for (n = 0; n < 3000 && sclOe; n++) tick(1);
      chk(16'(n), 16'((loM + 5) * 10));
      chk(16'(sclOut), 16'h0000);
      masterRun = 1'b0;
      for (n = 0; n < 3000 && !sclHighPhase; n++) tick(1);
      tmo();
      for (n = 0; n < 3000 && sclHighPhase; n++) tick(1);
      tmo();
      chk(16'(n >= (hiM + 5) * 10 + k * 20), 16'h0001);
      tick(4);
    end
    // Back-channel slave stretch and data setup count
    pulse(slaveStretchReq);
    tick(3);
    chk(16'(slaveSclHold), 16'h0001);
    pulse(slaveDataReady);
    for (n = 0; n < 3000 && slaveSclHold; n++) tick(1);
    tmo();
    chk(16'(n + 1 >= (loM + 5) * 10 && n <= (loM + 5) * 10 + 2), 16'h0001);
    test_done();
  end
endmodule : testbench
`default_nettype wire
